// *** hw/scpisr_pkg.sv ***
// Package: constants, map and carrier types of the status register system
`default_nettype none
package scpisr_pkg;
  // ----------------------------------------------------------------
  // Register groups (index of each status register)
  // ----------------------------------------------------------------
  localparam int NREG = 5;
  localparam int G_OPER = 0;
  localparam int G_QUES = 1;
  localparam int G_FREQ = 2;
  localparam int G_LIM = 3;
  localparam int G_POW = 4;
  // ----------------------------------------------------------------
  // Address map: group at 0x20*g, part at 4*p
  // ----------------------------------------------------------------
  localparam logic [3:0] P_COND = 4'h0;
  localparam logic [3:0] P_EVENT = 4'h1;
  localparam logic [3:0] P_ENABLE = 4'h2;
  localparam logic [3:0] P_PTR = 4'h3;
  localparam logic [3:0] P_NTR = 4'h4;
  localparam logic [3:0] P_EVPEEK = 4'h5;
  localparam logic [7:0] ADDR_CTRL = 8'hA0;
  localparam logic [7:0] ADDR_QUEUE = 8'hA4;
  localparam logic [7:0] ADDR_QLEVEL = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hAC;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hB0;
  localparam logic [7:0] ADDR_ERR_PUSH = 8'hB4;
  localparam int CTRL_PRESET_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  // ----------------------------------------------------------------
  // Reset and preset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PTR_PRESET = 16'hFFFF;
  localparam logic [15:0] NTR_PRESET = 16'h0000;
  localparam logic [15:0] ENA_PRESET_MAIN = 16'h0000;
  localparam logic [15:0] ENA_PRESET_SUB = 16'hFFFF;
  localparam logic [15:0] NO_ERROR = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Interrupt status bits
  localparam int IRQ_OPER_SUM = 0;
  localparam int IRQ_QUES_SUM = 1;
  localparam int IRQ_ERR_NEW = 2;
  localparam int IRQ_ERR_OVF = 3;
  localparam int IRQ_W = 4;

  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] event_bits;
    logic [15:0] enable;
    logic [15:0] ptr;
    logic [15:0] ntr;
  } scpisr_reg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRESP = 3'b010,
    ST_RRESP = 3'b100
  } scpisr_state_t;
endpackage : scpisr_pkg
`default_nettype wire

// *** hw/scpisr_top.sv ***
// Status register system with error queue behind an AXI4-Lite slave
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module scpisr_top #(
  parameter int QDEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] ques_cond_in,
  input wire logic [15:0] freq_cond_in,
  input wire logic [15:0] lim_cond_in,
  input wire logic [15:0] pow_cond_in,
  input wire logic err_valid,
  input wire logic [15:0] err_code,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic oper_summary,
  output logic ques_summary
);
  localparam int QAW = $clog2(QDEPTH);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  scpisr_pkg::scpisr_reg_t regs [scpisr_pkg::NREG];
  scpisr_pkg::scpisr_reg_t next_regs [scpisr_pkg::NREG];
  logic [15:0] prev_cond [scpisr_pkg::NREG];
  logic [15:0] next_prev_cond [scpisr_pkg::NREG];
  logic [15:0] queue [QDEPTH];
  logic [15:0] next_queue [QDEPTH];
  logic [QAW-1:0] qhead, next_qhead, qtail, next_qtail;
  logic [QAW:0] qcount, next_qcount;
  logic [scpisr_pkg::IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  scpisr_pkg::scpisr_state_t state, next_state;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic [31:0] rdata, next_rdata;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic next_irq, next_oper_sum, next_ques_sum;
  logic next_awready, next_wready, next_arready, next_bvalid, next_rvalid;

  function automatic logic summary_of(input scpisr_pkg::scpisr_reg_t r);
    summary_of = |(r.event_bits & r.enable);
  endfunction : summary_of

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a < scpisr_pkg::ADDR_CTRL && a[4:2] <= 3'(scpisr_pkg::P_EVPEEK)
      && a[1:0] == 2'h0) || a == scpisr_pkg::ADDR_CTRL || a == scpisr_pkg::ADDR_QUEUE
      || a == scpisr_pkg::ADDR_QLEVEL || a == scpisr_pkg::ADDR_IRQ_STAT
      || a == scpisr_pkg::ADDR_IRQ_MASK || a == scpisr_pkg::ADDR_ERR_PUSH;
  endfunction : known_addr

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] live [scpisr_pkg::NREG];
    logic [15:0] rise;
    logic [15:0] fall;
    logic do_write;
    logic do_read;
    logic preset;
    logic clear;
    logic pop;
    logic push;
    logic [2:0] rg;
    logic [3:0] pt;
    logic [15:0] wv;
    logic [scpisr_pkg::IRQ_W-1:0] ev;
    for (int g = 0; g < scpisr_pkg::NREG; g++) begin
      live[g] = 16'h0000;
    end
    rise = 16'h0000;
    fall = 16'h0000;
    ev = '0;
    do_write = 1'b0;
    do_read = 1'b0;
    rg = 3'h0;
    pt = 4'h0;
    wv = 16'h0000;
    next_regs = regs;
    next_prev_cond = prev_cond;
    next_queue = queue;
    next_qhead = qhead;
    next_qtail = qtail;
    next_qcount = qcount;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_state = state;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_rdata = rdata;
    next_bresp = bresp;
    next_rresp = rresp;
    preset = 1'b0;
    clear = 1'b0;
    pop = 1'b0;
    push = 1'b0;
    // Write channels taken in either order, held until both are in
    if (s_axi_awvalid && !aw_held && state == scpisr_pkg::ST_IDLE) begin
      next_aw_held = 1'b1;
      next_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held && state == scpisr_pkg::ST_IDLE) begin
      next_w_held = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && state == scpisr_pkg::ST_IDLE;
    // Reads yield to a complete write in the same cycle
    do_read = s_axi_arvalid && state == scpisr_pkg::ST_IDLE && !do_write;
    wv = {wdata[15:8] & {8{wstrb[1]}}, wdata[7:0] & {8{wstrb[0]}}};
    rg = waddr[7:5];
    pt = {1'b0, waddr[4:2]};
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_state = scpisr_pkg::ST_WRESP;
      next_bresp = known_addr(waddr) ? scpisr_pkg::RESP_OKAY : scpisr_pkg::RESP_SLVERR;
      if (waddr < scpisr_pkg::ADDR_CTRL && waddr[1:0] == 2'h0) begin
        case (pt)
          scpisr_pkg::P_ENABLE: next_regs[rg].enable = wv;
          scpisr_pkg::P_PTR: next_regs[rg].ptr = wv;
          scpisr_pkg::P_NTR: next_regs[rg].ntr = wv;
          default: next_regs[rg].enable = next_regs[rg].enable;
        endcase
      end else if (waddr == scpisr_pkg::ADDR_CTRL) begin
        preset = wv[scpisr_pkg::CTRL_PRESET_BIT];
        clear = wv[scpisr_pkg::CTRL_CLEAR_BIT];
      end else if (waddr == scpisr_pkg::ADDR_IRQ_STAT) begin
        next_irq_stat = irq_stat & ~wv[scpisr_pkg::IRQ_W-1:0];
      end else if (waddr == scpisr_pkg::ADDR_IRQ_MASK) begin
        next_irq_mask = wv[scpisr_pkg::IRQ_W-1:0];
      end else if (waddr == scpisr_pkg::ADDR_ERR_PUSH) begin
        push = 1'b1;
      end
    end
    if (do_read) begin
      next_state = scpisr_pkg::ST_RRESP;
      next_rresp = known_addr(s_axi_araddr) ? scpisr_pkg::RESP_OKAY
        : scpisr_pkg::RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      rg = s_axi_araddr[7:5];
      pt = {1'b0, s_axi_araddr[4:2]};
      if (s_axi_araddr < scpisr_pkg::ADDR_CTRL && known_addr(s_axi_araddr)) begin
        case (pt)
          scpisr_pkg::P_COND: next_rdata[15:0] = regs[rg].cond;
          scpisr_pkg::P_EVENT: begin
            next_rdata[15:0] = regs[rg].event_bits;
            next_regs[rg].event_bits = 16'h0000;
          end
          scpisr_pkg::P_ENABLE: next_rdata[15:0] = regs[rg].enable;
          scpisr_pkg::P_PTR: next_rdata[15:0] = regs[rg].ptr;
          scpisr_pkg::P_NTR: next_rdata[15:0] = regs[rg].ntr;
          default: next_rdata[15:0] = regs[rg].event_bits;
        endcase
      end else if (s_axi_araddr == scpisr_pkg::ADDR_QUEUE) begin
        if (qcount != '0) begin
          next_rdata = {{16{queue[qhead][15]}}, queue[qhead]};
          pop = 1'b1;
        end else begin
          next_rdata[15:0] = scpisr_pkg::NO_ERROR;
        end
      end else if (s_axi_araddr == scpisr_pkg::ADDR_QLEVEL) begin
        next_rdata[QAW:0] = qcount;
      end else if (s_axi_araddr == scpisr_pkg::ADDR_IRQ_STAT) begin
        next_rdata[scpisr_pkg::IRQ_W-1:0] = irq_stat;
      end else if (s_axi_araddr == scpisr_pkg::ADDR_IRQ_MASK) begin
        next_rdata[scpisr_pkg::IRQ_W-1:0] = irq_mask;
      end
    end
    if (state == scpisr_pkg::ST_WRESP && s_axi_bready) begin
      next_state = scpisr_pkg::ST_IDLE;
    end
    if (state == scpisr_pkg::ST_RRESP && s_axi_rready) begin
      next_state = scpisr_pkg::ST_IDLE;
    end
    // Clear-status drops events before new transitions so a same-cycle edge survives
    if (clear) begin
      for (int g = 0; g < scpisr_pkg::NREG; g++) begin
        next_regs[g].event_bits = 16'h0000;
      end
      next_qhead = '0;
      next_qtail = '0;
      next_qcount = '0;
      pop = 1'b0;
    end
    if (preset) begin
      for (int g = 0; g < scpisr_pkg::NREG; g++) begin
        next_regs[g].ptr = scpisr_pkg::PTR_PRESET;
        next_regs[g].ntr = scpisr_pkg::NTR_PRESET;
        next_regs[g].enable = (g <= scpisr_pkg::G_QUES) ? scpisr_pkg::ENA_PRESET_MAIN
          : scpisr_pkg::ENA_PRESET_SUB;
      end
    end
    // Condition sources; sub-register summaries fill the low questionable bits
    live[scpisr_pkg::G_OPER] = oper_cond_in;
    live[scpisr_pkg::G_FREQ] = freq_cond_in;
    live[scpisr_pkg::G_LIM] = lim_cond_in;
    live[scpisr_pkg::G_POW] = pow_cond_in;
    live[scpisr_pkg::G_QUES] = {ques_cond_in[15:3], summary_of(regs[scpisr_pkg::G_POW]),
      summary_of(regs[scpisr_pkg::G_LIM]), summary_of(regs[scpisr_pkg::G_FREQ])};
    for (int g = 0; g < scpisr_pkg::NREG; g++) begin
      rise = live[g] & ~prev_cond[g] & regs[g].ptr;
      fall = ~live[g] & prev_cond[g] & regs[g].ntr;
      next_regs[g].cond = live[g];
      next_prev_cond[g] = live[g];
      next_regs[g].event_bits = next_regs[g].event_bits | rise | fall;
    end
    // Error queue; a full queue drops the new entry and flags it
    if (pop) begin
      next_qhead = QAW'(qhead + 1'b1);
    end
    // Post-clear pointers, so a push beside clear-status lands in slot zero
    if (err_valid || push) begin
      if (next_qcount == (QAW+1)'(QDEPTH) && !pop) begin
        ev[scpisr_pkg::IRQ_ERR_OVF] = 1'b1;
      end else begin
        next_queue[next_qtail] = err_valid ? err_code : wv;
        next_qtail = QAW'(next_qtail + 1'b1);
        ev[scpisr_pkg::IRQ_ERR_NEW] = 1'b1;
      end
    end
    next_qcount = next_qcount + (QAW+1)'(ev[scpisr_pkg::IRQ_ERR_NEW]) - (QAW+1)'(pop);
    next_oper_sum = summary_of(next_regs[scpisr_pkg::G_OPER]);
    next_ques_sum = summary_of(next_regs[scpisr_pkg::G_QUES]);
    ev[scpisr_pkg::IRQ_OPER_SUM] = next_oper_sum && !oper_summary;
    ev[scpisr_pkg::IRQ_QUES_SUM] = next_ques_sum && !ques_summary;
    next_irq_stat = next_irq_stat | ev;
    next_irq = |(next_irq_stat & next_irq_mask);
    // Handshake flags follow the next state so each leaves a flop
    next_awready = !next_aw_held && next_state == scpisr_pkg::ST_IDLE;
    next_wready = !next_w_held && next_state == scpisr_pkg::ST_IDLE;
    next_arready = next_state == scpisr_pkg::ST_IDLE && !(next_aw_held && next_w_held);
    next_bvalid = next_state == scpisr_pkg::ST_WRESP;
    next_rvalid = next_state == scpisr_pkg::ST_RRESP;
  end

  // ----------------------------------------------------------------
  // Registers; aresetn clears cond and event parts and presets enable, ptr and ntr
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int g = 0; g < scpisr_pkg::NREG; g++) begin
        regs[g] <= '{cond: 16'h0000, event_bits: 16'h0000,
          enable: (g <= scpisr_pkg::G_QUES) ? scpisr_pkg::ENA_PRESET_MAIN
          : scpisr_pkg::ENA_PRESET_SUB, ptr: scpisr_pkg::PTR_PRESET,
          ntr: scpisr_pkg::NTR_PRESET};
        prev_cond[g] <= 16'h0000;
      end
      for (int i = 0; i < QDEPTH; i++) begin
        queue[i] <= 16'h0000;
      end
      qhead <= '0;
      qtail <= '0;
      qcount <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      state <= scpisr_pkg::ST_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      rdata <= 32'h0000_0000;
      bresp <= scpisr_pkg::RESP_OKAY;
      rresp <= scpisr_pkg::RESP_OKAY;
      irq <= 1'b0;
      oper_summary <= 1'b0;
      ques_summary <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
    end else if (ce) begin
      regs <= next_regs;
      prev_cond <= next_prev_cond;
      queue <= next_queue;
      qhead <= next_qhead;
      qtail <= next_qtail;
      qcount <= next_qcount;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      state <= next_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      rdata <= next_rdata;
      bresp <= next_bresp;
      rresp <= next_rresp;
      irq <= next_irq;
      oper_summary <= next_oper_sum;
      ques_summary <= next_ques_sum;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid <= next_bvalid;
      s_axi_rvalid <= next_rvalid;
    end
  end

  // Response payloads come straight from their flops
  assign s_axi_bresp = bresp;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
endmodule : scpisr_top
`default_nettype wire

// *** testbench/scpisr_chk.sv ***
// Checker: bus timing and sticky status outputs of the status register system
`default_nettype none
module scpisr_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic oper_summary,
  input wire logic ques_summary
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Bus quiet: nothing can clear an event, enable or status bit
  // ------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic quiet;
  assign quiet = s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_awvalid
    && !s_axi_wvalid && !s_axi_arvalid;
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  a_busy_no_read: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_oper_sticky: assert property (oper_summary && quiet |=> oper_summary)
    else $error("operation summary fell");
  a_ques_sticky: assert property (ques_summary && quiet |=> ques_summary)
    else $error("questionable summary fell");
  a_irq_sticky: assert property (irq && quiet |=> irq) else $error("interrupt fell");
  c_slow_bresp: cover property (s_axi_bvalid && !s_axi_bready);
  c_irq_rise: cover property ($rose(irq));
  c_ques_rise: cover property ($rose(ques_summary));
endmodule : scpisr_chk
bind scpisr_top scpisr_chk u_chk (.*);
`default_nettype wire

// *** testbench/scpisr_ctl_model.sv ***
// Controller model: AXI4-Lite master issuing status commands
`default_nettype none
module scpisr_ctl_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cycles of delay before accepting an answer
  int slow = 0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    // Released payload is scrambled so stale values are never trusted
    s_axi_wdata <= ~s_axi_wdata;
    repeat (slow) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (slow) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : scpisr_ctl_model
`default_nettype wire

// *** testbench/scpi_status_register_system_tb_top.sv ***
// Testbench: status register system driven through the controller model
`default_nettype none
module scpi_status_register_system_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, ce, err_valid;
  logic [15:0] oper_cond_in, ques_cond_in, freq_cond_in, lim_cond_in, pow_cond_in, err_code;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic irq, oper_summary, ques_summary;
  int n_fail = 0;
  int comparisons = 0;
  // Small queue so that overflow is cheap to reach
  scpisr_top #(.QDEPTH(4)) uut (.*);
  scpisr_ctl_model ctl (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    conclude();
  end
  // ------
  // Helpers
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rs;
    ctl.rd(a, v, rs);
    chk(v, exp);
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [1:0] rs;
    ctl.wr(a, v, rs);
    chk({30'h0, rs}, {30'h0, scpisr_pkg::RESP_OKAY});
  endtask : wr
  function automatic logic [7:0] ad(input int g, input logic [3:0] p);
    return 8'(g * 32 + 4 * int'(p));
  endfunction : ad
  task automatic push(input logic [15:0] c);
    @(posedge aclk);
    err_valid <= 1'b1;
    err_code <= c;
    @(posedge aclk);
    err_valid <= 1'b0;
    err_code <= ~c;
  endtask : push
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // ------
  // Tests
  // ------
  initial begin
    {aresetn, err_valid, err_code, oper_cond_in, ques_cond_in} = '0;
    {freq_cond_in, lim_cond_in, pow_cond_in} = '0;
    ce = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int g = 0; g < 5; g++) begin
      wr(ad(g, scpisr_pkg::P_PTR), 16'h0000);
      wr(ad(g, scpisr_pkg::P_NTR), 16'h1234);
      wr(ad(g, scpisr_pkg::P_ENABLE), 16'h00F0);
    end
    rdc(ad(3, scpisr_pkg::P_NTR), 32'h0000_1234);
    wr(scpisr_pkg::ADDR_CTRL, 16'h0001);
    for (int g = 0; g < 5; g++) begin
      rdc(ad(g, scpisr_pkg::P_PTR), 32'h0000_FFFF);
      rdc(ad(g, scpisr_pkg::P_NTR), 32'h0000_0000);
      rdc(ad(g, scpisr_pkg::P_ENABLE), g < 2 ? 32'h0 : 32'h0000_FFFF);
    end
    ctl.slow = 2;
    wr(ad(0, scpisr_pkg::P_PTR), 16'h0001);
    wr(ad(0, scpisr_pkg::P_NTR), 16'h0002);
    wr(ad(0, scpisr_pkg::P_ENABLE), 16'h0002);
    oper_cond_in <= 16'h0007;
    repeat (3) @(posedge aclk);
    rdc(ad(0, scpisr_pkg::P_COND), 32'h0000_0007);
    rdc(ad(0, scpisr_pkg::P_EVPEEK), 32'h0000_0001);
    chk(oper_summary, 1'b0);
    oper_cond_in <= 16'h0004;
    repeat (3) @(posedge aclk);
    rdc(ad(0, scpisr_pkg::P_COND), 32'h0000_0004);
    rdc(ad(0, scpisr_pkg::P_EVPEEK), 32'h0000_0003);
    chk(oper_summary, 1'b1);
    rdc(ad(0, scpisr_pkg::P_EVENT), 32'h0000_0003);
    rdc(ad(0, scpisr_pkg::P_EVPEEK), 32'h0000_0000);
    chk(oper_summary, 1'b0);
    ctl.slow = 0;
    wr(ad(1, scpisr_pkg::P_ENABLE), 16'h0001);
    freq_cond_in <= 16'h0100;
    repeat (3) @(posedge aclk);
    rdc(ad(1, scpisr_pkg::P_COND), 32'h0000_0001);
    chk(ques_summary, 1'b1);
    rdc(ad(2, scpisr_pkg::P_EVENT), 32'h0000_0100);
    rdc(ad(1, scpisr_pkg::P_EVPEEK), 32'h0000_0001);
    push(16'h0005);
    push(16'hFF9C);
    chk(irq, 1'b0);
    wr(scpisr_pkg::ADDR_IRQ_MASK, 16'h0004);
    chk(irq, 1'b1);
    wr(scpisr_pkg::ADDR_IRQ_STAT, 16'h0004);
    chk(irq, 1'b0);
    rdc(scpisr_pkg::ADDR_QLEVEL, 32'h0000_0002);
    rdc(scpisr_pkg::ADDR_QUEUE, 32'h0000_0005);
    rdc(scpisr_pkg::ADDR_QUEUE, 32'hFFFF_FF9C);
    rdc(scpisr_pkg::ADDR_QUEUE, 32'h0000_0000);
    for (int i = 1; i < 6; i++) push(16'(i));
    rdc(scpisr_pkg::ADDR_QLEVEL, 32'h0000_0004);
    wr(scpisr_pkg::ADDR_IRQ_MASK, 16'h0008);
    chk(irq, 1'b1);
    oper_cond_in <= 16'h0005;
    repeat (3) @(posedge aclk);
    wr(scpisr_pkg::ADDR_CTRL, 16'h0002);
    rdc(scpisr_pkg::ADDR_QLEVEL, 32'h0000_0000);
    rdc(ad(0, scpisr_pkg::P_EVPEEK), 32'h0000_0000);
    rdc(ad(0, scpisr_pkg::P_ENABLE), 32'h0000_0002);
    rdc(ad(0, scpisr_pkg::P_NTR), 32'h0000_0002);
    wr(scpisr_pkg::ADDR_ERR_PUSH, 16'hFFF0);
    rdc(scpisr_pkg::ADDR_QUEUE, 32'hFFFF_FFF0);
    // While ce is low the falling bit must not register; it does once ce returns
    oper_cond_in <= 16'h0007;
    repeat (2) @(posedge aclk);
    ce <= 1'b0;
    oper_cond_in <= 16'h0005;
    repeat (3) @(posedge aclk);
    chk(oper_summary, 1'b0);
    ce <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(oper_summary, 1'b1);
    rdc(ad(0, scpisr_pkg::P_EVENT), 32'h0000_0002);
    ctl.rd(8'hFC, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, scpisr_pkg::RESP_SLVERR});
    ctl.wr(8'h18, 16'h0001, r);
    chk({30'h0, r}, {30'h0, scpisr_pkg::RESP_SLVERR});
    conclude();
  end
endmodule : scpi_status_register_system_tb_top
`default_nettype wire
